/* hw/acr_ctrl.sv */
// converter control state machine and serial result readout
`timescale 1ns/10ps
`default_nettype none
module acr_ctrl
   import acr_pkg::*;
#(
   parameter int CONV_COUNT = CONV_CYCLES,
   parameter int POR_COUNT  = POR_CYCLES
) (
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire logic                   sck_i,
   input  wire logic                   cs_n_i,
   input  wire logic signed [IN_W-1:0] mod_value_i,
   output logic                        sdo_o,
   output logic                        sdo_oe_n_o,
   output logic                        low_power_o,
   output logic                        converting_o,
   output logic                        result_ready_o
);
   // terminal counts at timer width
   localparam logic [TMR_W-1:0] CONV_LAST = TMR_W'(CONV_COUNT - 1);
   localparam logic [TMR_W-1:0] POR_LAST  = TMR_W'(POR_COUNT - 1);
   localparam logic [TMR_W-1:0] TMR_ZERO  = '0;
   localparam logic [TMR_W-1:0] TMR_ONE   = TMR_W'(1);
   localparam logic [EDGE_W+1:0] SYNC_RST = {CS_RESET, SCK_RESET, EDGE_RESET};

   // ------------------------------------------------------------------
   // serial clock domain and crossings
   // ------------------------------------------------------------------
   logic [EDGE_W-1:0] edge_gray;
   logic [EDGE_W-1:0] edge_gray_s;
   logic              cs_s;
   logic              sck_s;

   acr_link_edges u_link (
      .sck_i       (sck_i),
      .cs_n_i      (cs_n_i),
      .edge_gray_o (edge_gray)
   );

   // pins and the gray edge count cross through two flops
   acr_sync #(
      .W       (EDGE_W + 2),
      .RST_VAL (SYNC_RST)
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({cs_n_i, sck_i, edge_gray}),
      .q_o   ({cs_s, sck_s, edge_gray_s})
   );

   // edge detection on the synchronised levels
   logic cs_d;
   logic cs_rise;
   logic cs_low;
   logic sck_high;
   logic sel_idle_low;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cs_d <= CS_RESET;
      end else begin
         cs_d <= cs_s;
      end
   end

   assign cs_rise      = cs_s & ~cs_d;
   assign cs_low       = ~cs_s;
   assign sck_high     = sck_s;
   assign sel_idle_low = cs_low & ~sck_s;

   // gray to binary, one xor reduction per bit
   logic [EDGE_W-1:0] edge_bin;
   genvar gi;
   generate
      for (gi = 0; gi < EDGE_W; gi++) begin : g_gray
         assign edge_bin[gi] = ^edge_gray_s[EDGE_W-1:gi];
      end
   endgenerate

   // ------------------------------------------------------------------
   // state and timer
   // ------------------------------------------------------------------
   acr_state_e        state;
   acr_state_e        next_state;
   logic [TMR_W-1:0]  timer;
   logic [TMR_W-1:0]  next_timer;
   logic [RES_W-1:0]  result;
   logic [RES_W-1:0]  next_result;
   logic [EDGE_W-1:0] edge_base;
   logic [EDGE_W-1:0] next_edge_base;

   logic in_por;
   logic in_conv;
   logic in_sleep;
   logic in_out;
   logic por_done;
   logic conv_done;

   assign in_por    = (state == ACR_POR);
   assign in_conv   = (state == ACR_CONV);
   assign in_sleep  = (state == ACR_SLEEP);
   assign in_out    = (state == ACR_OUT);
   assign por_done  = in_por & (timer == POR_LAST);
   assign conv_done = in_conv & (timer == CONV_LAST);

   // ------------------------------------------------------------------
   // result coding from the modulator value
   // ------------------------------------------------------------------
   logic              over_pos;
   logic              over_neg;
   logic [RES_W-1:0]  code_raw;
   logic [RES_W-1:0]  code;

   assign over_pos = (mod_value_i >= IN_POS_FS);
   assign over_neg = (mod_value_i <= IN_NEG_FS);
   // two's complement plus offset, so zero input reads as midscale
   assign code_raw = mod_value_i[RES_W-1:0] ^ CODE_OFFSET;
   assign code     = over_pos ? CODE_MAX :
                     over_neg ? CODE_MIN : code_raw;

   // ------------------------------------------------------------------
   // bit position within the data output state
   // ------------------------------------------------------------------
   logic [EDGE_W-1:0] bits_shifted;
   logic              word_done;
   logic [3:0]        bit_index;
   logic              cur_bit;

   // falling edges seen since entering data output
   assign bits_shifted = edge_bin - edge_base;
   assign word_done    = in_out & (bits_shifted >= BITS_PER_WORD);
   assign bit_index    = 4'(SIGN_BIT) - bits_shifted[3:0];
   // msb first, one step down per falling edge
   assign cur_bit      = result[bit_index];

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         ACR_POR: begin
            if (por_done) begin
               next_state = ACR_CONV;
            end
         end
         ACR_CONV: begin
            // interface activity is ignored until the timer runs out
            if (conv_done) begin
               next_state = ACR_SLEEP;
            end
         end
         ACR_SLEEP: begin
            if (sel_idle_low) begin
               next_state = ACR_OUT;
            end
         end
         ACR_OUT: begin
            if (cs_rise) begin
               next_state = ACR_CONV;
            end else if (word_done) begin
               next_state = ACR_CONV;
            end
         end
         default: begin
            next_state = ACR_POR;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // timer, result register and edge base
   // ------------------------------------------------------------------
   always_comb begin
      next_timer = timer + TMR_ONE;
      if (next_state != state) begin
         next_timer = TMR_ZERO;
      end else if (!(in_por || in_conv)) begin
         next_timer = TMR_ZERO;
      end
   end

   always_comb begin
      next_result = result;
      if (conv_done) begin
         // latest conversion only, replaced once per conversion
         next_result = code;
      end
   end

   always_comb begin
      next_edge_base = edge_base;
      if (in_sleep && sel_idle_low) begin
         next_edge_base = edge_bin;
      end
   end

   // power-on reset clears state, timer, result and edge base
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state     <= ACR_POR;
         timer     <= TMR_ZERO;
         result    <= RES_RESET;
         edge_base <= EDGE_RESET;
      end else begin
         state     <= next_state;
         timer     <= next_timer;
         result    <= next_result;
         edge_base <= next_edge_base;
      end
   end

   // ------------------------------------------------------------------
   // serial data pin and status outputs
   // ------------------------------------------------------------------
   logic next_sdo;
   logic next_oe_n;
   logic next_low_power;
   logic next_converting;
   logic next_ready;
   logic status_bit;

   // busy while converting or held in power-on reset, done in sleep
   assign status_bit = in_sleep ? STAT_DONE : STAT_BUSY;

   always_comb begin
      next_sdo = status_bit;
      if (in_out) begin
         next_sdo = cur_bit;
      end else if (in_sleep && sel_idle_low) begin
         // sign bit is ready on the pin as the state is entered
         next_sdo = result[SIGN_BIT];
      end else if (cs_low && sck_high) begin
         next_sdo = status_bit;
      end
   end

   assign next_oe_n       = cs_s;
   assign next_low_power  = in_sleep & cs_s;
   assign next_converting = in_conv | in_por;
   assign next_ready      = in_sleep | in_out;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sdo_o          <= STAT_BUSY;
         sdo_oe_n_o     <= CS_RESET;
         low_power_o    <= 1'b0;
         converting_o   <= 1'b1;
         result_ready_o <= 1'b0;
      end else begin
         sdo_o          <= next_sdo;
         sdo_oe_n_o     <= next_oe_n;
         low_power_o    <= next_low_power;
         converting_o   <= next_converting;
         result_ready_o <= next_ready;
      end
   end
endmodule : acr_ctrl
`default_nettype wire

/* hw/acr_link_edges.sv */
// serial clock domain: counts falling edges while chip select is low
`timescale 1ns/10ps
`default_nettype none
module acr_link_edges
   import acr_pkg::*;
(
   input  wire logic              sck_i,
   input  wire logic              cs_n_i,
   output logic [EDGE_W-1:0]      edge_gray_o
);
   logic [EDGE_W-1:0] edge_cnt;
   logic [EDGE_W-1:0] next_cnt;

   assign next_cnt = edge_cnt + 6'h01;

   // chip select high clears the count, the frame's own end
   always_ff @(negedge sck_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         edge_cnt    <= EDGE_RESET;
         edge_gray_o <= EDGE_RESET;
      end else begin
         edge_cnt    <= next_cnt;
         edge_gray_o <= next_cnt ^ (next_cnt >> 1);
      end
   end
endmodule : acr_link_edges
`default_nettype wire

/* hw/acr_pkg.sv */
// shared constants for the converter control and serial readout block
package acr_pkg;
   // internal clock rate in kHz
   localparam int          CLK_FREQ_KHZ   = 125000;
   // conversion time in milliseconds, nominal figure
   localparam real         CONV_TIME_MS   = 16.6;
   // power-on hold time in milliseconds
   localparam real         POR_TIME_MS    = 0.5;
   // derived cycle counts
   localparam int          CONV_CYCLES    = int'(CONV_TIME_MS * CLK_FREQ_KHZ);
   localparam int          POR_CYCLES     = int'(POR_TIME_MS * CLK_FREQ_KHZ);
   // timer width, enough for the conversion count
   localparam int          TMR_W          = 22;
   // result word
   localparam int          RES_W          = 16;
   localparam int          SIGN_BIT       = 15;
   localparam int          IN_W           = 17;
   localparam logic [15:0] RES_RESET      = 16'h0000;
   localparam logic [15:0] CODE_MAX       = 16'hFFFF;
   localparam logic [15:0] CODE_MIN       = 16'h0000;
   localparam logic [15:0] CODE_OFFSET    = 16'h8000;
   localparam logic signed [16:0] IN_POS_FS = 17'sh07FFF;
   localparam logic signed [16:0] IN_NEG_FS = -17'sh08000;
   // serial clock falling edge counter
   localparam int          EDGE_W         = 6;
   localparam logic [5:0]  EDGE_RESET     = 6'h00;
   localparam logic [5:0]  BITS_PER_WORD  = 6'h10;
   // synchroniser reset values: chip select idles high
   localparam logic        CS_RESET       = 1'b1;
   localparam logic        SCK_RESET      = 1'b0;
   // status levels on the data pin
   localparam logic        STAT_BUSY      = 1'b1;
   localparam logic        STAT_DONE      = 1'b0;
   // operating states
   typedef enum logic [1:0] {
      ACR_POR,
      ACR_CONV,
      ACR_SLEEP,
      ACR_OUT
   } acr_state_e;
endpackage : acr_pkg

/* hw/acr_sync.sv */
// two-flop synchroniser, one stage pair per bit
`timescale 1ns/10ps
`default_nettype none
module acr_sync
   import acr_pkg::*;
#(
   parameter int           W         = 1,
   parameter logic [W-1:0] RST_VAL   = '0
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta;
         logic stable;
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               meta   <= RST_VAL[i];
               stable <= RST_VAL[i];
            end else begin
               meta   <= d_i[i];
               stable <= meta;
            end
         end
         assign q_o[i] = stable;
      end
   endgenerate
endmodule : acr_sync
`default_nettype wire

/* tb/acr_ctrl_chk.sv */
// assertion checker for the converter control block
`timescale 1ns/10ps
`default_nettype none
module acr_ctrl_chk
   import acr_pkg::*;
#(
   parameter int CONV_COUNT = CONV_CYCLES,
   parameter int POR_COUNT  = POR_CYCLES
) (
   input wire logic                   clk_i,
   input wire logic                   rst_i,
   input wire logic                   sck_i,
   input wire logic                   cs_n_i,
   input wire logic signed [IN_W-1:0] mod_value_i,
   input wire logic                   sdo_o,
   input wire logic                   sdo_oe_n_o,
   input wire logic                   low_power_o,
   input wire logic                   converting_o,
   input wire logic                   result_ready_o
);
   int   cnt;
   logic len_ok;
   assign len_ok = (cnt >= CONV_COUNT - 1 && cnt <= CONV_COUNT + 1)
                || (cnt >= CONV_COUNT + POR_COUNT - 1 && cnt <= CONV_COUNT + POR_COUNT + 1);
   always_ff @(posedge clk_i) cnt <= (rst_i || !converting_o) ? 0 : cnt + 1;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_reset_state: assert property ($fell(rst_i) |-> converting_o && !result_ready_o)
      else $error("bad state after reset");
   a_conv_sleep: assert property ($fell(converting_o) |-> ##[0:1] result_ready_o)
      else $error("convert not followed by sleep");
   a_out_conv: assert property ($fell(result_ready_o) |-> ##[0:1] converting_o)
      else $error("output not followed by convert");
   a_state_excl: assert property (!(converting_o && result_ready_o))
      else $error("two states at once");
   a_conv_length: assert property ($fell(converting_o) |-> len_ok)
      else $error("conversion length wrong");
   a_no_abort: assert property (converting_o && cnt < CONV_COUNT - 1 |=> converting_o)
      else $error("conversion cut short");
   a_lp_sleep: assert property (low_power_o |-> result_ready_o && $past(cs_n_i, 3))
      else $error("low power outside idle sleep");
   a_oe_off: assert property (cs_n_i [*4] |-> sdo_oe_n_o)
      else $error("data driven while deselected");
   a_oe_on: assert property (!cs_n_i [*4] |-> !sdo_oe_n_o)
      else $error("data not driven while selected");
   a_busy_level: assert property (
      converting_o && $past(converting_o) && !sdo_oe_n_o |-> sdo_o)
      else $error("busy level missing");
   a_bit_stands: assert property (
      (result_ready_o && !sdo_oe_n_o && sck_i) [*8] ##1 (result_ready_o && !sdo_oe_n_o)
      |-> $stable(sdo_o))
      else $error("data bit moved while clock high");
endmodule : acr_ctrl_chk
bind acr_ctrl acr_ctrl_chk #(.CONV_COUNT(CONV_COUNT), .POR_COUNT(POR_COUNT)) acr_ctrl_chk_i (
   .clk_i(clk_i), .rst_i(rst_i), .sck_i(sck_i), .cs_n_i(cs_n_i), .mod_value_i(mod_value_i),
   .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o), .low_power_o(low_power_o),
   .converting_o(converting_o), .result_ready_o(result_ready_o));
`default_nettype wire

/* tb/acr_ctrl_tb_top.sv */
// self-checking bench for the converter control and readout block
`timescale 1ns/10ps
`default_nettype none
module acr_ctrl_tb_top;
   import acr_pkg::*;
   logic                   clk_i = 1'b0;
   logic                   clk_link = 1'b0;
   logic                   rst_i = 1'b1;
   logic signed [IN_W-1:0] mod_value_i = '0;
   wire logic              sck, cs_n, sdo, oe_n, low_power, converting, ready, h_done;
   wire logic [15:0]       h_word;
   wire logic [4:0]        h_bits;
   logic [15:0]            exp_q[$];
   int                     bad_count = 0;
   int                     n_compared = 0;
   int                     cyc = 0;
   always #4 clk_i = ~clk_i;
   initial begin
      #1.3;
      forever #6 clk_link = ~clk_link;
   end
   acr_ctrl #(.CONV_COUNT(200), .POR_COUNT(20)) acr_ctrl_i (.clk_i(clk_i), .rst_i(rst_i),
      .sck_i(sck), .cs_n_i(cs_n), .mod_value_i(mod_value_i), .sdo_o(sdo), .sdo_oe_n_o(oe_n),
      .low_power_o(low_power), .converting_o(converting), .result_ready_o(ready));
   acr_host_model acr_host_model_i (.clk_link_i(clk_link), .sdo_i(sdo), .sdo_oe_n_i(oe_n),
      .sck_o(sck), .cs_n_o(cs_n), .word_o(h_word), .bits_o(h_bits), .done_o(h_done));
   function automatic logic [15:0] code_of(input logic signed [IN_W-1:0] v);
      if (v > IN_POS_FS) return CODE_MAX;
      if (v < IN_NEG_FS) return CODE_MIN;
      return 16'(v) ^ CODE_OFFSET;
   endfunction : code_of
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict
   task automatic wait_sleep(input logic conv_first);
      for (int i = 0; i < 600 && conv_first && converting !== 1'b1; i++) @(posedge clk_i);
      for (int i = 0; i < 600 && ready !== 1'b1; i++) @(posedge clk_i);
      @(negedge clk_i);
      check({15'h0000, ready}, 16'h0001);
   endtask : wait_sleep
   always @(posedge h_done) begin : watch
      logic [15:0] mask;
      mask = 16'hFFFF << (16 - ((h_bits == 5'h00) ? 1 : int'(h_bits)));
      if (exp_q.size() == 0)
         check(16'h0000, 16'hFFFF);
      else
         check(h_word & mask, exp_q.pop_front() & mask);
   end
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         bad_count++;
         give_verdict();
      end
   end
   initial begin : main
      logic                   s;
      logic signed [IN_W-1:0] cur_v;
      logic signed [IN_W-1:0] vals [8];
      int                     nb [8];
      logic                   cp [8];
      cur_v = IN_W'($urandom(38));
      vals = '{17'sh07FFF, 17'sh08000, -17'sh08000, -17'sh08001, 17'sh00000, -17'sh00001,
               IN_W'($urandom()), IN_W'($urandom())};
      nb = '{16, 16, 16, 7, 0, 16, 16, 16};
      cp = '{0, 1, 0, 1, 0, 1, 0, 1};
      @(negedge clk_i);
      mod_value_i = cur_v;
      repeat (10) @(negedge clk_i);
      rst_i = 1'b0;
      check({15'h0000, converting}, 16'h0001);
      acr_host_model_i.status(s);
      check({15'h0000, s}, 16'h0001);
      wait_sleep(1'b0);
      acr_host_model_i.status(s);
      check({15'h0000, s}, 16'h0000);
      check({15'h0000, low_power}, 16'h0001);
      for (int k = 0; k < 8; k++) begin
         exp_q.push_back(code_of(cur_v));
         cur_v = vals[k];
         mod_value_i = cur_v;
         acr_host_model_i.read_word(nb[k], cp[k]);
         if (k == 2) begin
            acr_host_model_i.status(s);
            check({15'h0000, s}, 16'h0001);
         end
         wait_sleep(1'b1);
      end
      rst_i = 1'b1;
      repeat (4) @(negedge clk_i);
      check({14'h0000, converting, ready}, 16'h0002);
      rst_i = 1'b0;
      repeat (2) @(negedge clk_i);
      check({14'h0000, converting, ready}, 16'h0002);
      give_verdict();
   end
endmodule : acr_ctrl_tb_top
`default_nettype wire

/* tb/acr_host_model.sv */
// host serial master model that reads result words
`timescale 1ns/10ps
`default_nettype none
module acr_host_model (
   input  wire logic        clk_link_i,
   input  wire logic        sdo_i,
   input  wire logic        sdo_oe_n_i,
   output logic             sck_o,
   output logic             cs_n_o,
   output logic [15:0]      word_o,
   output logic [4:0]       bits_o,
   output logic             done_o
);
   localparam int HALF = 21;
   logic last_q = 1'b0;
   logic line;
   // released line shows the inverse of the last driven level
   assign line = sdo_oe_n_i ? ~last_q : sdo_i;
   always @(posedge clk_link_i) if (!sdo_oe_n_i) last_q <= sdo_i;
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      word_o = '0;
      bits_o = '0;
      done_o = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk_link_i);
   endtask : hold
   task automatic read_word(input int nbits, input logic cpol);
      logic [15:0] w;
      sck_o = cpol;
      cs_n_o = 1'b0;
      hold(HALF);
      if (cpol) begin
         sck_o = 1'b0;
         hold(HALF);
      end
      w = '0;
      w[15] = line;
      for (int i = 0; i < nbits; i++) begin
         w[15-i] = line;
         sck_o = 1'b1;
         hold(HALF);
         sck_o = 1'b0;
         hold(HALF);
      end
      cs_n_o = 1'b1;
      hold(HALF);
      word_o = w;
      bits_o = nbits[4:0];
      done_o = 1'b1;
      hold(1);
      done_o = 1'b0;
   endtask : read_word
   task automatic status(output logic s);
      sck_o = 1'b1;
      hold(2);
      cs_n_o = 1'b0;
      hold(HALF);
      s = line;
      cs_n_o = 1'b1;
      hold(HALF);
      sck_o = 1'b0;
   endtask : status
endmodule : acr_host_model
`default_nettype wire
